// [verilog/otp_verify_pkg.sv]
// constants for the blind verify sequencer
package otp_verify_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLP_NS = CLK_PERIOD_NS;  // one clock period unit is one mclk period
  localparam int STROBE_PERIOD_CLP = 3;
  localparam int SAMPLE_DELAY_CLP = 3;
  localparam int STROBE_PERIOD_CYC = (STROBE_PERIOD_CLP * CLP_NS) / CLK_PERIOD_NS;
  localparam int SAMPLE_DELAY_CYC = (SAMPLE_DELAY_CLP * CLP_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
  localparam logic [1:0] PHASE_LAST = 2'(STROBE_PERIOD_CYC - 1);
  localparam logic [1:0] PHASE_FIRST = 2'h0;

  // ****************************************
  // grouping and sizes
  // ****************************************
  localparam int GROUP_BYTES = 16;
  localparam logic [3:0] GROUP_LAST = 4'(GROUP_BYTES - 1);
  localparam int DATA_W = 8;
  localparam int OTP_ADDR_W = 13;
  localparam int OTP_BYTES = 8192;
  localparam int BUF_DEPTH = 2;

  // ****************************************
  // mode selection and protection
  // ****************************************
  localparam logic MODE_FETCH_LEVEL = 1'b0;
  localparam logic MODE_ACCESS_LEVEL = 1'b1;
  localparam logic MODE_STROBE_LEVEL = 1'b1;
  localparam logic [1:0] LOCK_LEVEL1 = 2'h2;  // high bit unprogrammed, low bit programmed
  localparam logic FETCH_ACTIVE = 1'b0;
  localparam logic RESULT_PASS = 1'b1;
  localparam logic RESULT_FAIL = 1'b0;

  typedef enum {
    SEQ_IDLE,
    SEQ_RUN,
    SEQ_DRAIN,
    SEQ_DONE
  } seq_state_t;

endpackage

// [verilog/byte_stream_if.sv]
// valid/ready carrier for sampled bytes with their addresses
`timescale 1ns/1ps
interface byte_stream_if #(
  parameter int W = 21
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [verilog/pair_buffer.sv]
// small valid/ready buffer in the sample path
`timescale 1ns/1ps
module pair_buffer #(
  parameter int W     = 21,
  parameter int DEPTH = otp_verify_pkg::BUF_DEPTH
) (
  input  wire logic   mclk,
  input  wire logic   rst_n,
  byte_stream_if.snk  fill,
  byte_stream_if.src  drain
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;
  logic          push;
  logic          pop;

  // handshakes and honest full/empty
  assign fill.ready  = (count != (PW+1)'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.data  = mem[rd_ptr];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  // storage
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= fill.data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  a_buf_no_overrun: assert property (@(posedge mclk) disable iff (!rst_n)
    count <= (PW+1)'(DEPTH))
    else $error("buffer holds more than its depth");
endmodule

// [verilog/otp_blind_verify_sequencer.sv]
// blind verify sequencer for a protected one-time-programmable code memory
// Notes on behaviour
// RL1: tester sets mode pins; device starts the sequence when reset releases.
// RL2: address strobe pulses once every three clock period units while running.
// RL3: no address leaves the device during the sequence.
// RL4: tester presents location zero byte for the first strobe after reset.
// RL5: each later strobe advances the pointer; tester supplies the next byte.
// RL6: data bus sampled three units after strobe rise, compared at pointer.
// RL7: a mismatch is remembered until the current group result is reported.
// RL8: after every sixteenth compare, the group pass or fail goes out.
// RL9: result pin low for fail, high for pass, steady through next group.
// RL10: tester keeps the system clock running for the whole mode.
// RL11: tester counts strobes in a fourteen-bit counter addressing its image.
// RL12: tester may latch the result pin on the strobe falling edge.
// RL13: after the last byte the device drives the program fetch strobe.
// RL14: tester sees the end from fetch strobe or its counter carry out.
// RL15: this mode is how content is checked at protection level one.
// RL16: level one is lock bits 1,0; only this mode reads the memory.
// RL17: at the end strobes stop and the last result stays on the pin.
`timescale 1ns/1ps
module otp_blind_verify_sequencer #(
  parameter int OTP_BYTES  = otp_verify_pkg::OTP_BYTES,
  parameter int OTP_ADDR_W = otp_verify_pkg::OTP_ADDR_W
) (
  input  wire logic                              mclk,
  input  wire logic                              rst_n,
  input  wire logic [1:0]                        lock_bits,
  input  wire logic                              external_access_select,
  input  wire logic                              program_fetch_strobe_in,
  output logic                                   program_fetch_strobe_out,
  output logic                                   program_fetch_strobe_oe,
  input  wire logic                              address_strobe_in,
  output logic                                   address_strobe_out,
  output logic                                   address_strobe_oe,
  input  wire logic [otp_verify_pkg::DATA_W-1:0] port0_data_in,
  output logic                                   verify_result_pin,
  output logic                                   verify_result_oe,
  output logic [OTP_ADDR_W-1:0]                  otp_addr,
  input  wire logic [otp_verify_pkg::DATA_W-1:0] otp_rdata
);
  localparam int DW = otp_verify_pkg::DATA_W;
  localparam int SW = DW + 3;
  localparam int EW = OTP_ADDR_W + DW;
  localparam logic [OTP_ADDR_W-1:0] ADDR_LAST = OTP_ADDR_W'(OTP_BYTES - 1);
  localparam logic [SW-1:0] SYNC_RESET = {~otp_verify_pkg::MODE_FETCH_LEVEL,
                                          ~otp_verify_pkg::MODE_ACCESS_LEVEL,
                                          ~otp_verify_pkg::MODE_STROBE_LEVEL, DW'(0)};

  otp_verify_pkg::seq_state_t state;
  logic [SW-1:0]          s1;
  logic [SW-1:0]          s2;
  logic [SW-1:0]          s3;
  logic [SW-1:0]          filt;
  logic [1:0]             lock_q;
  logic                   lock_taken;
  logic                   mode_ok;
  logic                   level_ok;
  logic [1:0]             phase;
  logic                   seen;
  logic                   step;
  logic                   more;
  logic [OTP_ADDR_W-1:0]  ptr;
  logic                   strobe;
  logic [1:0]             pend;
  logic [OTP_ADDR_W-1:0]  pend_ptr;
  logic                   cmp_busy;
  logic [DW-1:0]          expected;
  logic [3:0]             grp;
  logic                   err_acc;
  logic                   mismatch;
  logic                   report;

  byte_stream_if #(.W(EW)) sample_if ();
  byte_stream_if #(.W(EW)) cmp_if ();

  // ****************************************
  // pin synchronisers
  // ****************************************

  // three stages; a bit changes once stages two and three agree
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1   <= SYNC_RESET;
      s2   <= SYNC_RESET;
      s3   <= SYNC_RESET;
      filt <= SYNC_RESET;
    end else begin
      s1   <= {program_fetch_strobe_in, external_access_select, address_strobe_in,
               port0_data_in};
      s2   <= s1;
      s3   <= s2;
      filt <= (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
    end
  end

  // lock strap caught once after reset release
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lock_q     <= 2'h0;
      lock_taken <= 1'b0;
    end else if (!lock_taken) begin
      lock_q     <= lock_bits;
      lock_taken <= 1'b1;
    end
  end

  assign mode_ok  = (filt[SW-1] == otp_verify_pkg::MODE_FETCH_LEVEL)
                 && (filt[SW-2] == otp_verify_pkg::MODE_ACCESS_LEVEL)
                 && (filt[SW-3] == otp_verify_pkg::MODE_STROBE_LEVEL);  // RL1
  assign level_ok = lock_taken && (lock_q == otp_verify_pkg::LOCK_LEVEL1);  // RL15 RL16

  // ****************************************
  // sequence control
  // ****************************************

  assign step = (state == otp_verify_pkg::SEQ_RUN) && (phase == otp_verify_pkg::PHASE_LAST);
  assign more = !(seen && (ptr == ADDR_LAST));

  // state walk: wait, strobe, let compares finish, end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= otp_verify_pkg::SEQ_IDLE;
    end else begin
      case (state)
        otp_verify_pkg::SEQ_IDLE: begin
          if (mode_ok && level_ok) begin
            state <= otp_verify_pkg::SEQ_RUN;  // RL1
          end
        end
        otp_verify_pkg::SEQ_RUN: begin
          if (step && sample_if.ready && !more) begin
            state <= otp_verify_pkg::SEQ_DRAIN;
          end
        end
        otp_verify_pkg::SEQ_DRAIN: begin
          if ((pend == 2'h0) && !cmp_if.valid && !cmp_busy) begin
            state <= otp_verify_pkg::SEQ_DONE;  // RL13
          end
        end
        default: begin
          state <= otp_verify_pkg::SEQ_DONE;  // RL17
        end
      endcase
    end
  end

  // strobe phase; holds on a full buffer so no sample is lost
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase <= otp_verify_pkg::PHASE_LAST;
    end else if (state != otp_verify_pkg::SEQ_RUN) begin
      phase <= otp_verify_pkg::PHASE_LAST;
    end else if (phase != otp_verify_pkg::PHASE_LAST) begin
      phase <= phase + 2'h1;
    end else if (sample_if.ready) begin
      phase <= otp_verify_pkg::PHASE_FIRST;
    end
  end

  // strobe pulse, first one addresses location zero; pend delays the sample past the synchroniser
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strobe   <= 1'b0;
      seen     <= 1'b0;
      ptr      <= '0;
      pend     <= 2'h0;
      pend_ptr <= '0;
    end else begin
      strobe <= step && sample_if.ready && more;  // RL2 RL17
      pend   <= {pend[0], step && sample_if.ready && seen};  // RL6
      if (step && sample_if.ready) begin
        seen     <= 1'b1;  // RL4
        pend_ptr <= ptr;
        if (seen && more) begin
          ptr <= ptr + OTP_ADDR_W'(1);  // RL5
        end
      end
    end
  end

  // pin byte of three cycles after the strobe rise, seen through the synchroniser lag
  assign sample_if.valid = pend[1];  // RL6
  assign sample_if.data  = {pend_ptr, filt[DW-1:0]};

  pair_buffer #(.W(EW), .DEPTH(otp_verify_pkg::BUF_DEPTH)) u_buf (
    .mclk  (mclk),
    .rst_n (rst_n),
    .fill  (sample_if),
    .drain (cmp_if)
  );

  // ****************************************
  // compare and group result
  // ****************************************

  assign cmp_if.ready = !cmp_busy;
  assign mismatch     = cmp_busy && (otp_rdata != expected);
  assign report       = cmp_busy && ((grp == otp_verify_pkg::GROUP_LAST)
                                     || (otp_addr == ADDR_LAST));

  // fetch the stored byte, compare on the next cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmp_busy <= 1'b0;
      otp_addr <= '0;
      expected <= '0;
    end else if (cmp_if.valid && !cmp_busy) begin
      cmp_busy <= 1'b1;
      otp_addr <= cmp_if.data[EW-1:DW];  // RL6
      expected <= cmp_if.data[DW-1:0];
    end else begin
      cmp_busy <= 1'b0;
    end
  end

  // error accumulation and group count
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      grp     <= 4'h0;
      err_acc <= 1'b0;
    end else if (cmp_busy) begin
      grp <= grp + 4'h1;
      if (report) begin
        err_acc <= 1'b0;  // RL7
      end else if (mismatch) begin
        err_acc <= 1'b1;  // RL7
      end
    end
  end

  // result pin, steady between reports
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      verify_result_pin <= otp_verify_pkg::RESULT_PASS;
    end else if (report) begin
      verify_result_pin <= (err_acc || mismatch) ? otp_verify_pkg::RESULT_FAIL
                                                 : otp_verify_pkg::RESULT_PASS;  // RL8 RL9
    end
  end

  // ****************************************
  // pin drive
  // ****************************************

  // only strobe, result and end marker leave the device; never an address
  assign address_strobe_out       = strobe;  // RL3
  assign address_strobe_oe        = (state != otp_verify_pkg::SEQ_IDLE);
  assign verify_result_oe         = (state != otp_verify_pkg::SEQ_IDLE);
  assign program_fetch_strobe_out = otp_verify_pkg::FETCH_ACTIVE;
  assign program_fetch_strobe_oe  = (state == otp_verify_pkg::SEQ_DONE);  // RL13

  // ****************************************
  // checks
  // ****************************************

  a_start_on_mode: assert property (@(posedge mclk) disable iff (!rst_n)  // RL1
    (state == otp_verify_pkg::SEQ_IDLE) && mode_ok && level_ok
      |=> (state == otp_verify_pkg::SEQ_RUN) ##1 address_strobe_out)
    else $error("sequence did not start with a strobe");

  a_strobe_period: assert property (@(posedge mclk) disable iff (!rst_n)  // RL2
    $rose(address_strobe_out) && more |-> ##1 !address_strobe_out [*2] ##1
      (address_strobe_out || !$past(sample_if.ready)))
    else $error("strobe period is not three cycles");

  a_no_fetch_run: assert property (@(posedge mclk) disable iff (!rst_n)  // RL13
    (state != otp_verify_pkg::SEQ_DONE) |-> !program_fetch_strobe_oe)
    else $error("fetch strobe driven before the end");

  a_pointer_step: assert property (@(posedge mclk) disable iff (!rst_n)  // RL5
    $rose(address_strobe_out) ##3 $rose(address_strobe_out)
      |-> ptr == $past(ptr, 3) + OTP_ADDR_W'(1))
    else $error("pointer did not advance by one per strobe");

  a_sample_delay: assert property (@(posedge mclk) disable iff (!rst_n)  // RL6
    $rose(address_strobe_out) ##2 (step && sample_if.ready) |-> ##2 sample_if.valid)
    else $error("sample not taken three cycles after strobe");

  a_error_kept: assert property (@(posedge mclk) disable iff (!rst_n)  // RL7
    mismatch && !report |=> err_acc)
    else $error("mismatch not remembered");

  a_fail_reported: assert property (@(posedge mclk) disable iff (!rst_n)  // RL8
    report && (err_acc || mismatch) |=> (verify_result_pin == otp_verify_pkg::RESULT_FAIL))
    else $error("failing group reported as pass");

  a_result_steady: assert property (@(posedge mclk) disable iff (!rst_n)  // RL9
    !report |=> $stable(verify_result_pin))
    else $error("result pin moved between reports");

  a_end_marker: assert property (@(posedge mclk) disable iff (!rst_n)  // RL13
    (state == otp_verify_pkg::SEQ_DRAIN) && (pend == 2'h0) && !cmp_if.valid && !cmp_busy
      |=> program_fetch_strobe_oe && (program_fetch_strobe_out == otp_verify_pkg::FETCH_ACTIVE))
    else $error("end marker not driven after last byte");

  a_quiet_end: assert property (@(posedge mclk) disable iff (!rst_n)  // RL17
    (state == otp_verify_pkg::SEQ_DONE) |-> !address_strobe_out && !sample_if.valid)
    else $error("activity after the end");

  a_level_one_only: assert property (@(posedge mclk) disable iff (!rst_n)  // RL16
    (state != otp_verify_pkg::SEQ_IDLE) |-> (lock_q == otp_verify_pkg::LOCK_LEVEL1))
    else $error("sequence ran outside level one");
endmodule

// [tb/otp_tester.sv]
// tester model: strobe-clocked address counter feeding a reference image
`timescale 1ns/1ps
module otp_tester (
  input  wire logic        rst_n,
  input  wire logic        strobe,
  input  wire logic        dev_started,
  input  wire logic        ea_level,
  input  wire logic [63:0] bad_mask,
  output logic [7:0]       data,
  output logic             ext_access,
  output logic             fetch_lvl,
  output logic             fetch_oe,
  output logic             ale_lvl,
  output logic [13:0]      cnt,
  output logic             carry_out,
  input  wire logic        result_pin,
  output logic             result_latched
);
  logic first;

  // ****************************************
  // reference image and mode pins
  // ****************************************
  function automatic logic [7:0] img(input logic [13:0] a);
    return 8'(a * 14'h001d + 14'h0035);
  endfunction

  // mode levels stand until the device takes the pins over
  assign ext_access = ea_level;
  assign fetch_lvl  = otp_verify_pkg::MODE_FETCH_LEVEL;
  assign fetch_oe   = !dev_started;
  assign ale_lvl    = otp_verify_pkg::MODE_STROBE_LEVEL;
  assign carry_out  = &cnt;

  // counter steps on strobes after the first; wrong bytes only where commanded
  always @(posedge strobe or negedge rst_n) begin
    if (!rst_n) begin
      cnt   <= 14'h0000;
      first <= 1'b1;
    end else if (first) begin
      first <= 1'b0;
    end else begin
      cnt <= cnt + 14'h0001;
    end
  end

  assign data = img(cnt) ^ (bad_mask[cnt[5:0]] ? 8'hff : 8'h00);

  // verify detect: result pin caught on the strobe falling edge
  always @(negedge strobe) begin
    result_latched <= result_pin;
  end
endmodule

// [tb/testbench.sv]
// self-checking bench for the blind verify sequencer
`timescale 1ns/1ps
module testbench;
  localparam int NB = 48;
  logic        mclk;
  logic        rst_n;
  logic [1:0]  lock_bits;
  logic        ea_level;
  logic [63:0] bad_mask;
  logic        pfs_out, pfs_oe, ale_out, ale_oe, res_pin, res_oe;
  logic        tst_ea, tst_fetch, tst_fetch_oe, tst_ale, carry;
  logic [7:0]  p0, otp_rdata;
  logic [12:0] otp_addr;
  logic [13:0] tst_cnt;
  logic        tst_res;
  wire         pfs_wire = pfs_oe ? pfs_out : (tst_fetch_oe ? tst_fetch : 1'b1);
  wire         ale_wire = ale_oe ? ale_out : tst_ale;
  int          errors, tests_run, cyc, nstr;
  int          stamp[64];
  logic        res[64];

  // ****************************************
  // clock, memory, instances, monitor
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // on-chip image, data valid in the cycle after the address register moves
  assign otp_rdata = 8'(otp_addr * 13'h001d + 13'h0035);

  otp_blind_verify_sequencer #(.OTP_BYTES(NB)) DUT (
    .mclk(mclk), .rst_n(rst_n), .lock_bits(lock_bits),
    .external_access_select(tst_ea), .program_fetch_strobe_in(pfs_wire),
    .program_fetch_strobe_out(pfs_out), .program_fetch_strobe_oe(pfs_oe),
    .address_strobe_in(ale_wire), .address_strobe_out(ale_out),
    .address_strobe_oe(ale_oe), .port0_data_in(p0), .verify_result_pin(res_pin),
    .verify_result_oe(res_oe), .otp_addr(otp_addr), .otp_rdata(otp_rdata));

  otp_tester tester (
    .rst_n(rst_n), .strobe(ale_out & ale_oe), .dev_started(ale_oe),
    .ea_level(ea_level), .bad_mask(bad_mask), .data(p0), .ext_access(tst_ea),
    .fetch_lvl(tst_fetch), .fetch_oe(tst_fetch_oe), .ale_lvl(tst_ale),
    .cnt(tst_cnt), .carry_out(carry), .result_pin(res_pin), .result_latched(tst_res));

  // stamp every strobe and the result level seen with it
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (rst_n && ale_out === 1'b1 && nstr < 64) begin
      stamp[nstr] = cyc;
      res[nstr] = res_pin;
      nstr = nstr + 1;
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] lk, input logic ea, input logic [63:0] m);
    @(negedge mclk);
    rst_n = 1'b0;
    lock_bits = lk;
    ea_level = ea;
    bad_mask = m;
    repeat (8) @(negedge mclk);
    nstr = 0;
    rst_n = 1'b1;
  endtask

  // full run, then strobe spacing, group results and end marking
  task automatic run_and_check(input logic [63:0] m);
    int   n;
    int   g;
    int   k;
    logic eg[3];
    do_reset(2'h2, 1'h1, m);
    n = 0;
    while (pfs_oe !== 1'b1 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 1000) begin
      errors++;
      $display("BAD %0t sequence never ended", $time);
      final_report();
    end
    for (g = 0; g < 3; g++) eg[g] = (m[16*g +: 16] == 16'h0000);
    check("strobe count", nstr, NB);
    for (k = 1; k < nstr; k++) check("strobe period", stamp[k] - stamp[k-1], 3);
    for (k = 0; k < 16; k++) check("result before report", res[k], 1'h1);
    for (g = 0; g < 2; g++) begin
      for (k = 16*g + 20; k < 16*g + 32; k++) check("group result", res[k], eg[g]);
    end
    check("fetch level", pfs_out, otp_verify_pkg::FETCH_ACTIVE);
    check("fetch wire", pfs_wire, 1'h0);
    check("tester count", tst_cnt, NB - 1);
    check("tester latch", tst_res, eg[1]);
    repeat (30) @(negedge mclk);
    check("no strobe after end", nstr, NB);
    check("final result", res_pin, eg[2]);
    check("result driven", res_oe, 1'h1);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_restart();
    int n;
    do_reset(2'h2, 1'h1, 64'h0000_0000_0000_0000);
    n = 0;
    while (nstr < 10 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    check("strobes before restart", nstr, 10);
    if (n >= 200) final_report();
    check("strobe enable", ale_oe, 1'h1);
    run_and_check(64'h0000_0000_0000_0000);
  endtask

  task automatic s_fail_at_group_end();
    run_and_check(64'h0000_8000_0000_8000);
  endtask

  task automatic s_fail_at_group_start();
    run_and_check(64'h0000_0000_0001_0000);
  endtask

  task automatic s_refuse();
    logic [2:0] cs[4] = '{3'h7, 3'h3, 3'h1, 3'h4};
    int         i;
    for (i = 0; i < 4; i++) begin
      do_reset(cs[i][2:1], cs[i][0], 64'h0000_0000_0000_0000);
      repeat (60) @(negedge mclk);
      check("refused strobes", nstr, 0);
      check("refused strobe oe", ale_oe, 1'h0);
      check("refused result oe", res_oe, 1'h0);
      check("refused fetch oe", pfs_oe, 1'h0);
    end
  endtask

  initial begin
    rst_n = 1'b0;
    lock_bits = 2'h2;
    ea_level = 1'h1;
    bad_mask = 64'h0000_0000_0000_0000;
    errors = 0;
    tests_run = 0;
    cyc = 0;
    nstr = 0;
    s_restart();
    s_fail_at_group_end();
    s_fail_at_group_start();
    s_refuse();
    final_report();
  end
endmodule
